/* rtl/dual_counter_capture.sv */
// Two 16-bit counters with shared capture register and byte readout bus
`timescale 1ns/100ps
module dual_counter_capture
   import dual_counter_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_count_clock_first,
   input wire logic i_count_clock_second,
   input wire logic i_second_count_enable_n,
   input wire logic i_counters_clear_n,
   input wire logic i_capture_clock,
   input wire logic i_sel_first_low_byte_n,
   input wire logic i_sel_first_high_byte_n,
   input wire logic i_sel_second_low_byte_n,
   input wire logic i_sel_second_high_byte_n,
   output logic o_first_full_count_n,
   output logic [7:0] o_byte_out_bus,
   output logic [7:0] o_byte_out_bus_oe_n
);

   // ==================================================================
   // Pin synchronisers
   // Edges of pin clocks are sampled on i_ref_clk; pin rates must stay
   // well below a quarter of the reference to avoid missed edges.
   logic rise_first;
   logic rise_second;
   logic rise_cap;
   logic en_second_n_s;
   logic clr_n_s;
   logic [3:0] sel_n_s;

   edge_sync #(.RST_VAL(1'b0)) u_sync_first (
      .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_pin(i_count_clock_first),
      .o_level(), .o_rise(rise_first));
   edge_sync #(.RST_VAL(1'b0)) u_sync_second (
      .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_pin(i_count_clock_second),
      .o_level(), .o_rise(rise_second));
   edge_sync #(.RST_VAL(1'b0)) u_sync_cap (
      .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_pin(i_capture_clock),
      .o_level(), .o_rise(rise_cap));
   edge_sync #(.RST_VAL(1'b1)) u_sync_en (
      .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_pin(i_second_count_enable_n),
      .o_level(en_second_n_s), .o_rise());

   // Selects, one synchroniser each, idle high
   logic [3:0] sel_pins;
   assign sel_pins = {i_sel_second_high_byte_n, i_sel_second_low_byte_n,
                      i_sel_first_high_byte_n, i_sel_first_low_byte_n};
   for (genvar g = 0; g < 4; g++) begin : g_sel
      edge_sync #(.RST_VAL(1'b1)) u_sync_sel (
         .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_pin(sel_pins[g]),
         .o_level(sel_n_s[g]), .o_rise());
   end

   // ==================================================================
   // Clear: asynchronous assert, synchronous release
   // The clear pin acts on the flops directly; release is resynchronised
   // so no counter flop leaves reset on a metastable edge.
   logic clr_meta_ff;
   logic clr_sync_ff;
   logic clr_any_n;
   assign clr_any_n = i_rstn & i_counters_clear_n;

   always_ff @(posedge i_ref_clk or negedge clr_any_n) begin
      if (!clr_any_n) begin
         clr_meta_ff <= 1'b0;
         clr_sync_ff <= 1'b0;
      end else begin
         clr_meta_ff <= 1'b1;
         clr_sync_ff <= clr_meta_ff;
      end
   end
   assign clr_n_s = clr_sync_ff;

   // Combined counter clear: pin low, or its release not yet through
   // the two flops. The pin half zeroes the counters at once; the
   // synchronised half keeps them at zero until a clean edge.
   logic clr_n_s_async;
   assign clr_n_s_async = clr_any_n & clr_n_s;

   // ==================================================================
   // Counters
   capture_s cnt_ff;
   capture_s nxt_cnt;

   // Next counts
   always_comb begin
      nxt_cnt = cnt_ff;
      if (rise_first) begin
         nxt_cnt.first = cnt_ff.first + 16'h0001;
      end
      if (rise_second && !en_second_n_s) begin
         nxt_cnt.second = cnt_ff.second + 16'h0001;
      end
   end

   // Count registers, zeroed at once by the clear pin
   always_ff @(posedge i_ref_clk or negedge clr_n_s_async) begin
      if (!clr_n_s_async) begin
         cnt_ff <= {CNT_RST, CNT_RST};
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // ==================================================================
   // Full-count flag, capture and readout
   capture_s cap_ff;
   capture_s nxt_cap;
   logic full_n_ff;
   logic nxt_full_n;
   bus_drive_s bus_ff;
   bus_drive_s nxt_bus;

   // Next flag, capture and bus
   always_comb begin
      nxt_full_n = ~(nxt_cnt.first == CNT_FULL);
      nxt_cap = cap_ff;
      if (rise_cap) begin
         nxt_cap = cnt_ff;
      end                                           // Otherwise held
      if (one_sel(sel_n_s)) begin
         nxt_bus.data = pick_byte(sel_n_s, cap_ff);
         nxt_bus.oe_n = 8'h00;
      end else begin
         nxt_bus.data = BYTE_RST;                   // Float
         nxt_bus.oe_n = 8'hff;
      end
   end

   // Flag clears with the counters; output is straight off this flop
   always_ff @(posedge i_ref_clk or negedge clr_n_s_async) begin
      if (!clr_n_s_async) begin
         full_n_ff <= 1'b1;
      end else begin
         full_n_ff <= nxt_full_n;
      end
   end

   // Capture and bus registers, only the system reset touches them
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cap_ff <= CAP_RST;
         bus_ff <= {BYTE_RST, 8'hff};
      end else begin
         cap_ff <= nxt_cap;
         bus_ff <= nxt_bus;
      end
   end

   assign o_first_full_count_n = full_n_ff;
   assign o_byte_out_bus = bus_ff.data;
   assign o_byte_out_bus_oe_n = bus_ff.oe_n;

   // ==================================================================
   // Checks
   // Everything below except a_clear_zero is judged after the pin synchronisers, so
   // those checks run on the internal edge pulses and synchronised levels; a_clear_zero reads the clear pin.

   // One counted edge on the first pin
   sequence s_first_edge;
      rise_first;
   endsequence

   // One counted edge on the second pin while its enable is low
   sequence s_second_edge;
      rise_second && !en_second_n_s;
   endsequence

   // First counter at full count and about to wrap
   sequence s_first_wrap;
      (cnt_ff.first == CNT_FULL) && rise_first;
   endsequence

   // Counting and clearing
   a_first_incr: assert property (@(posedge i_ref_clk) disable iff (!clr_n_s_async)
      s_first_edge |=> cnt_ff.first == $past(cnt_ff.first) + 16'h0001)
      else $error("first counter did not step");
   a_first_hold: assert property (@(posedge i_ref_clk) disable iff (!clr_n_s_async)
      !rise_first |=> $stable(cnt_ff.first))
      else $error("first counter moved without edge");
   a_second_step: assert property (@(posedge i_ref_clk) disable iff (!clr_n_s_async)
      s_second_edge |=> cnt_ff.second == $past(cnt_ff.second) + 16'h0001)
      else $error("second counter did not step");
   a_second_hold: assert property (@(posedge i_ref_clk) disable iff (!clr_n_s_async)
      !(rise_second && !en_second_n_s) |=> $stable(cnt_ff.second))
      else $error("second counter moved while disabled");
   a_wrap_zero: assert property (@(posedge i_ref_clk) disable iff (!clr_n_s_async)
      s_first_wrap |=> cnt_ff.first == CNT_RST)
      else $error("first counter did not wrap");
   a_clear_zero: assert property (@(posedge i_ref_clk)
      !i_counters_clear_n |-> cnt_ff == {CNT_RST, CNT_RST})
      else $error("clear did not zero counters");
   a_clear_release: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $rose(clr_n_s_async) |-> cnt_ff == {CNT_RST, CNT_RST})
      else $error("counters not zero on clear release");

   // Full-count flag, a level copy of the first count
   a_full_flag: assert property (@(posedge i_ref_clk) disable iff (!clr_n_s_async)
      (cnt_ff.first == CNT_FULL) |-> !full_n_ff)
      else $error("full flag not low at full count");
   a_flag_release: assert property (@(posedge i_ref_clk) disable iff (!clr_n_s_async)
      (cnt_ff.first != CNT_FULL) |-> full_n_ff)
      else $error("full flag low below full count");

   // Capture register
   a_capture_copy: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      rise_cap |=> cap_ff == $past(cnt_ff))
      else $error("capture missed");
   a_capture_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !rise_cap |=> $stable(cap_ff))
      else $error("capture changed without edge");

   // Readout bus; bytes land one cycle after the synchronised select
   a_byte_drive: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (sel_n_s == SEL_FIRST_HI) |=> bus_ff.oe_n == 8'h00 &&
      bus_ff.data == $past(cap_ff.first[15:8]))
      else $error("wrong byte driven");
   a_byte_lsb: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (sel_n_s == SEL_FIRST_LO) |=> bus_ff.data == $past(cap_ff.first[7:0]))
      else $error("low byte bit order wrong");
   a_byte_second: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (sel_n_s == SEL_SECOND_HI) |=> bus_ff.oe_n == 8'h00 &&
      bus_ff.data == $past(cap_ff.second[15:8]))
      else $error("wrong second byte driven");
   a_bus_float: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (sel_n_s == SEL_NONE) |=> bus_ff.oe_n == 8'hff)
      else $error("bus not floated");
   a_multi_float: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !one_sel(sel_n_s) |=> bus_ff.oe_n == 8'hff)
      else $error("bus driven without a single select");

endmodule : dual_counter_capture

/* rtl/dual_counter_pkg.sv */
// Constants and carrier types for the dual counter with byte-wide capture readout
package dual_counter_pkg;

   // ==================================================================
   // Widths and reset values
   localparam int CNT_W = 16;                     // One counter
   localparam int BYTE_W = 8;                     // Output bus
   localparam logic [15:0] CNT_RST = 16'h0000;    // Cleared count
   localparam logic [15:0] CNT_FULL = 16'hffff;   // Full count
   localparam logic [31:0] CAP_RST = 32'h0000_0000;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // ==================================================================
   // Byte field positions in the capture word
   localparam int FIRST_LO_POS = 0;
   localparam int FIRST_HI_POS = 8;
   localparam int SECOND_LO_POS = 16;
   localparam int SECOND_HI_POS = 24;

   // Byte-select codes, active low, order {sec_hi, sec_lo, first_hi, first_lo}
   localparam logic [3:0] SEL_NONE = 4'hf;
   localparam logic [3:0] SEL_FIRST_LO = 4'he;
   localparam logic [3:0] SEL_FIRST_HI = 4'hd;
   localparam logic [3:0] SEL_SECOND_LO = 4'hb;
   localparam logic [3:0] SEL_SECOND_HI = 4'h7;

   // Snapshot of both counters
   typedef struct packed {
      logic [15:0] second;
      logic [15:0] first;
   } capture_s;

   // Readout pin group
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] oe_n;
   } bus_drive_s;

   // Pick the byte for a select code; unknown codes give zero
   function automatic logic [7:0] pick_byte(input logic [3:0] sel_n, input capture_s cap);
      logic [31:0] w;
      w = cap;
      case (sel_n)
         SEL_FIRST_LO: pick_byte = w[FIRST_LO_POS +: 8];
         SEL_FIRST_HI: pick_byte = w[FIRST_HI_POS +: 8];
         SEL_SECOND_LO: pick_byte = w[SECOND_LO_POS +: 8];
         SEL_SECOND_HI: pick_byte = w[SECOND_HI_POS +: 8];
         default: pick_byte = BYTE_RST;
      endcase
   endfunction : pick_byte

   // True when exactly one select is low
   function automatic logic one_sel(input logic [3:0] sel_n);
      one_sel = (sel_n == SEL_FIRST_LO) || (sel_n == SEL_FIRST_HI) ||
         (sel_n == SEL_SECOND_LO) || (sel_n == SEL_SECOND_HI);
   endfunction : one_sel

endpackage : dual_counter_pkg

/* rtl/edge_sync.sv */
// Two-flop synchroniser with rising-edge pulse for one pin
`timescale 1ns/100ps
module edge_sync
   import dual_counter_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_pin,
   output logic o_level,
   output logic o_rise
);

   // ==================================================================
   // Synchroniser chain; first flop feeds only the second
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;
   logic nxt_meta;
   logic nxt_sync;
   logic nxt_prev;

   // Next-state
   always_comb begin
      nxt_meta = i_pin;
      nxt_sync = meta_ff;
      nxt_prev = sync_ff;
   end

   // Registers
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
         prev_ff <= RST_VAL;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         prev_ff <= nxt_prev;
      end
   end

   assign o_level = sync_ff;
   assign o_rise = sync_ff & ~prev_ff;   // Edge seen after synchronising

endmodule : edge_sync

/* test/dual_counter_capture_tb.sv */
// Self-checking bench for the dual counter with byte readout
`timescale 1ns/100ps
module dual_counter_capture_tb;
   import dual_counter_pkg::*;
   // ==================================================================
   // Stimulus and observation
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic clk_first = 1'b0;
   logic clk_second = 1'b0;
   logic en2_n = 1'b0;
   logic clr_n = 1'b1;
   logic cap_clk = 1'b0;
   logic rd = 1'b0;
   logic [1:0] idx = 2'h0;
   logic [3:0] sel_n;
   logic [7:0] seen;
   logic flag_n;
   logic [7:0] bus;
   logic [7:0] bus_oe_n;
   logic chain = 1'b0;
   logic en2_pin;
   int err_count = 0;
   int num_checks = 0;

   // 200 MHz reference clock
   always #2.5 ref_clk = ~ref_clk;

   // Board wiring: chained form feeds the full flag to the second enable
   assign en2_pin = chain ? flag_n : en2_n;

   dual_counter_capture dual_counter_capture_inst (
      .i_ref_clk(ref_clk), .i_rstn(rstn),
      .i_count_clock_first(clk_first), .i_count_clock_second(clk_second),
      .i_second_count_enable_n(en2_pin), .i_counters_clear_n(clr_n),
      .i_capture_clock(cap_clk),
      .i_sel_first_low_byte_n(sel_n[0]), .i_sel_first_high_byte_n(sel_n[1]),
      .i_sel_second_low_byte_n(sel_n[2]), .i_sel_second_high_byte_n(sel_n[3]),
      .o_first_full_count_n(flag_n), .o_byte_out_bus(bus),
      .o_byte_out_bus_oe_n(bus_oe_n));

   host_byte_reader host_byte_reader_inst (
      .i_ref_clk(ref_clk), .i_rd(rd), .i_idx(idx), .i_bus(bus),
      .i_bus_oe_n(bus_oe_n), .o_sel_n(sel_n), .o_seen(seen));

   // ==================================================================
   // Shared tasks
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Pins held 3 cycles high and 3 low, above the 2-cycle minimum
   task automatic pulse(input logic f, input logic s);
      tick(1);
      clk_first <= f;
      clk_second <= s;
      tick(3);
      clk_first <= 1'b0;
      clk_second <= 1'b0;
      tick(3);
   endtask : pulse

   task automatic capture();
      tick(1);
      cap_clk <= 1'b1;
      tick(3);
      cap_clk <= 1'b0;
      tick(3);
   endtask : capture

   // Four byte reads, with a long all-high gap before each select
   task automatic read_all(input logic [31:0] exp);
      for (int i = 0; i < 4; i++) begin
         tick(40);
         rd <= 1'b1;
         idx <= i[1:0];
         tick(5);
         #1;
         check("bus_oe_n", {24'h0000_00, bus_oe_n}, 32'h0000_0000);
         check("byte", {24'h0000_00, seen}, {24'h0000_00, exp[8*i +: 8]});
         tick(1);
         rd <= 1'b0;
      end
      tick(5);
      #1;
      check("float", {24'h0000_00, bus_oe_n}, 32'h0000_00ff);
   endtask : read_all

   // ==================================================================
   // Scenarios; wrap and the chained carry into the second counter need 65536 pulses, too long for this run
   task automatic t_reset();
      #1;
      check("flag_n", {31'h0, flag_n}, 32'h0000_0001);
      check("oe_n", {24'h0000_00, bus_oe_n}, 32'h0000_00ff);
      $display("test reset done");
   endtask : t_reset

   task automatic t_count_read();
      repeat (3) pulse(1'b1, 1'b1);
      repeat (2) pulse(1'b1, 1'b0);
      capture();
      read_all(32'h0003_0005);
      $display("test count_read done");
   endtask : t_count_read

   task automatic t_enable_gate();
      tick(1);
      en2_n <= 1'b1;
      tick(3);
      repeat (2) pulse(1'b1, 1'b1);
      en2_n <= 1'b0;
      tick(3);
      capture();
      read_all(32'h0003_0007);
      $display("test enable_gate done");
   endtask : t_enable_gate

   task automatic t_hold_clear();
      pulse(1'b1, 1'b1);
      read_all(32'h0003_0007);
      tick(1);
      clr_n <= 1'b0;
      capture();
      #1;
      check("flag_clr", {31'h0, flag_n}, 32'h0000_0001);
      clr_n <= 1'b1;
      tick(4);
      read_all(32'h0000_0000);
      pulse(1'b1, 1'b1);
      capture();
      read_all(32'h0001_0001);
      $display("test hold_clear done");
   endtask : t_hold_clear

   // Chained form: one clock source, flag high keeps the second counter still
   task automatic t_chain();
      tick(1);
      chain <= 1'b1;
      tick(3);
      repeat (2) pulse(1'b1, 1'b1);
      #1;
      check("flag_chain", {31'h0, flag_n}, 32'h0000_0001);
      tick(1);
      chain <= 1'b0;
      capture();
      read_all(32'h0001_0003);
      $display("test chain done");
   endtask : t_chain

   // ==================================================================
   // Verdict
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   // Main sequence after a 10-cycle reset
   initial begin
      tick(10);
      rstn <= 1'b1;
      tick(3);
      t_reset();
      t_count_read();
      t_enable_gate();
      t_hold_clear();
      t_chain();
      complete_run();
   end

   // Whole run needs about 1300 cycles; 20000 means a hang
   initial begin
      tick(20000);
      err_count++;
      complete_run();
   end
endmodule : dual_counter_capture_tb

/* test/host_byte_reader.sv */
// Host-side model: address decoder that turns a byte index into one select
`timescale 1ns/100ps
module host_byte_reader
   import dual_counter_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rd,
   input wire logic [1:0] i_idx,
   input wire logic [7:0] i_bus,
   input wire logic [7:0] i_bus_oe_n,
   output logic [3:0] o_sel_n,
   output logic [7:0] o_seen
);
   // ==================================================================
   // Decoder
   logic [7:0] last_ff; // Last byte the device really drove

   // One select low per read, all high when idle
   always_comb begin
      o_sel_n = SEL_NONE;
      if (i_rd) begin
         o_sel_n[i_idx] = 1'b0;
      end
   end

   // Remember the driven byte so a released bus can show something else
   always_ff @(posedge i_ref_clk) begin
      if (i_bus_oe_n == 8'h00) begin
         last_ff <= i_bus;
      end
   end

   // A floating bus must never look like valid data, so invert the last byte
   assign o_seen = (i_bus_oe_n == 8'h00) ? i_bus : ~last_ff;
endmodule : host_byte_reader
